// ===== verilog/return_instruction_exec.sv
// decode and execute of the return-from-interrupt and return-with-literal operations
`timescale 1ns/1ps

// ****************************************
// timing of one return, in core clocks
// ****************************************
// c0 q1 edge: word taken, busy rises after it
// c1, c2 q2 and q3 edges: nothing sampled
// c3 q4 edge: stack top, shadows and level sampled
// c4 q1 edge: pulses and new data seen for one clock
// c5 to c7: second cycle, a bubble; fetched word dropped
// after c7: busy low, the next q1 edge may take again
// limitation: a word offered while busy is lost, not queued
// trade-off: one clock of lag buys glitch-free registered pulses
`include "rie_regs.svh"

module return_instruction_exec
  import rie_pkg::*;
(
  input wire logic clk, // core clock, 200 mhz
  input wire logic reset_n, // async reset, active low
  input wire logic [1:0] qPhase, // quarter phase of instruction cycle
  input wire logic instrValid, // instruction word valid at q1
  input wire logic [`RIE_INSTR_W-1:0] instrWord, // fetched instruction word
  input wire logic returnHighLevel, // 1: leaving high priority handler
  input wire logic [`RIE_PC_W-1:0] stackTopEntry, // return stack top
  input wire logic [`RIE_ACC_W-1:0] accumulatorShadow, // accumulator shadow copy
  input wire logic [`RIE_FLAG_W-1:0] flagsShadow, // flags shadow copy
  input wire logic [`RIE_BANK_W-1:0] bankSelectShadow, // bank select shadow copy
  output logic busy, // return operation in flight
  output logic stackPop, // pop return stack, one pulse
  output logic pcLoad, // load pc from pcNext, one pulse
  output logic [`RIE_PC_W-1:0] pcNext, // new program counter
  output logic accumWrite, // write accumulator, one pulse
  output logic [`RIE_ACC_W-1:0] accumData, // accumulator value
  output logic flagsWrite, // write status flags, one pulse
  output logic [`RIE_FLAG_W-1:0] flagsData, // status value
  output logic bankWrite, // write bank select register, one pulse
  output logic [`RIE_BANK_W-1:0] bankData, // bank select value
  output logic highIrqEnableSet, // set high_priority_global_irq_enable
  output logic lowIrqEnableSet // set low_priority_global_irq_enable
);

  // ****************************************
  // state
  // ****************************************
  rie_state_s st_reg; // registered state
  rie_state_s st_next; // next state
  logic isRfi; // word matches interrupt return
  logic isRwl; // word matches literal return
  logic atQ1; // first quarter
  logic atQ4; // last quarter

  // ****************************************
  // decode
  // ****************************************
  // pure pattern match, no state involved
  // any word outside both masks leaves the unit idle
  assign isRfi = (instrWord & `RIE_RFI_MASK) == `RIE_RFI_CODE;
  assign isRwl = (instrWord & `RIE_RWL_MASK) == `RIE_RWL_CODE;
  assign atQ1 = qPhase == `RIE_Q1;
  assign atQ4 = qPhase == `RIE_Q4;

  // ****************************************
  // next state
  // ****************************************
  // write pulses last one clock; data outputs hold until next return
  // literal and selector are latched at q1 so a later word cannot leak in
  // shadows are read at q4 only, as late as the sequence allows
  always_comb begin
    st_next = st_reg;
    st_next.pcLoad = 1'b0;
    st_next.accumWrite = 1'b0;
    st_next.flagsWrite = 1'b0;
    st_next.bankWrite = 1'b0;
    st_next.highSet = 1'b0;
    st_next.lowSet = 1'b0;
    case (st_reg.state)
      RIE_IDLE: begin
        // words other than the two returns are not ours
        if (instrValid && atQ1 && (isRfi || isRwl)) begin
          st_next.state = RIE_EXEC;
          st_next.op = isRfi ? RIE_OP_RFI : RIE_OP_RWL;
          st_next.shadowSel = isRfi && instrWord[`RIE_SHADOW_BIT];
          st_next.literal = instrWord[`RIE_LIT_HI:`RIE_LIT_LO];
        end
      end
      RIE_EXEC: begin
        // everything happens together at q4 of the first cycle
        if (atQ4) begin
          st_next.state = RIE_FLUSH;
          // pc is loaded from the return stack top here, for both kinds of return
          st_next.pcLoad = 1'b1;
          st_next.pcNext = stackTopEntry;
          if (st_reg.op == RIE_OP_RWL) begin
            st_next.accumWrite = 1'b1;
            st_next.accumData = st_reg.literal;
          end else begin
            // the enable of the level being left is set; flags change only with s=1
            st_next.highSet = returnHighLevel;
            st_next.lowSet = !returnHighLevel;
            if (st_reg.shadowSel) begin
              st_next.accumWrite = 1'b1;
              st_next.accumData = accumulatorShadow;
              st_next.flagsWrite = 1'b1;
              st_next.flagsData = flagsShadow;
              st_next.bankWrite = 1'b1;
              st_next.bankData = bankSelectShadow;
            end
            // s=0: no accumulator, flags or bank strobes, registers keep their values
          end
        end
      end
      RIE_FLUSH: begin
        // second cycle is a bubble; the prefetched word is dropped
        if (atQ4) begin
          st_next.state = RIE_IDLE;
        end
      end
      default: begin
        st_next.state = RIE_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  // reset clears the pulses too, so a reset mid-return leaves no half write
  // the reset branch holds constants only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg.state <= RIE_IDLE;
      st_reg.op <= RIE_OP_RFI;
      st_reg.shadowSel <= 1'b0;
      st_reg.literal <= `RIE_ACC_RST;
      st_reg.pcNext <= `RIE_PC_RST;
      st_reg.accumData <= `RIE_ACC_RST;
      st_reg.flagsData <= `RIE_FLAG_RST;
      st_reg.bankData <= `RIE_BANK_RST;
      st_reg.pcLoad <= 1'b0;
      st_reg.accumWrite <= 1'b0;
      st_reg.flagsWrite <= 1'b0;
      st_reg.bankWrite <= 1'b0;
      st_reg.highSet <= 1'b0;
      st_reg.lowSet <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // busy is a handshake, so combinational from state
  // the pop strobe is the load strobe; stack and pc move together
  assign busy = st_reg.state != RIE_IDLE;
  assign stackPop = st_reg.pcLoad;
  assign pcLoad = st_reg.pcLoad;
  assign pcNext = st_reg.pcNext;
  assign accumWrite = st_reg.accumWrite;
  assign accumData = st_reg.accumData;
  assign flagsWrite = st_reg.flagsWrite;
  assign flagsData = st_reg.flagsData;
  assign bankWrite = st_reg.bankWrite;
  assign bankData = st_reg.bankData;
  assign highIrqEnableSet = st_reg.highSet;
  assign lowIrqEnableSet = st_reg.lowSet;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // all checks share the core clock and go quiet in reset;
  // pulses are judged one clock after the q4 edge that made
  // them, which is why most properties key on pcLoad

  chk_rfi_decode: assert property (
    (!busy && instrValid && atQ1 && isRfi)
      |=> (st_reg.state == RIE_EXEC && st_reg.op == RIE_OP_RFI
           && st_reg.shadowSel == $past(instrWord[`RIE_SHADOW_BIT])))
    else $error("interrupt return not decoded");

  chk_rfi_pop: assert property (
    (st_reg.state == RIE_EXEC && atQ4)
      |=> (pcLoad && stackPop && pcNext == $past(stackTopEntry)))
    else $error("pc not loaded from stack top");

  chk_enable_set: assert property (
    (pcLoad && st_reg.op == RIE_OP_RFI)
      |-> ((highIrqEnableSet ^ lowIrqEnableSet)
           && highIrqEnableSet == $past(returnHighLevel)))
    else $error("wrong interrupt enable set");

  chk_shadow_restore: assert property (
    (pcLoad && st_reg.op == RIE_OP_RFI && st_reg.shadowSel)
      |-> (accumWrite && flagsWrite && bankWrite
           && accumData == $past(accumulatorShadow)
           && flagsData == $past(flagsShadow)
           && bankData == $past(bankSelectShadow)))
    else $error("shadow restore wrong");

  chk_no_restore: assert property (
    (pcLoad && st_reg.op == RIE_OP_RFI && !st_reg.shadowSel)
      |-> (!accumWrite && !flagsWrite && !bankWrite))
    else $error("registers written with s clear");

  chk_flags_only_restore: assert property (
    flagsWrite |-> (st_reg.op == RIE_OP_RFI && st_reg.shadowSel))
    else $error("flags written outside shadow restore");

  chk_rwl_decode: assert property (
    (!busy && instrValid && atQ1 && isRwl)
      |=> (st_reg.op == RIE_OP_RWL
           && st_reg.literal == $past(instrWord[`RIE_LIT_HI:`RIE_LIT_LO])))
    else $error("literal return not decoded");

  chk_rwl_accum: assert property (
    (pcLoad && st_reg.op == RIE_OP_RWL)
      |-> (accumWrite && accumData == st_reg.literal && !flagsWrite && !bankWrite))
    else $error("literal not written to accumulator");

  chk_rwl_no_enable: assert property (
    (pcLoad && st_reg.op == RIE_OP_RWL) |-> (!highIrqEnableSet && !lowIrqEnableSet))
    else $error("literal return touched interrupt enable");

  chk_two_cycles: assert property (
    pcLoad |-> (busy && !$past(pcLoad)) ##1 (busy && !pcLoad) [*3] ##1 !busy)
    else $error("second cycle length wrong");

  // pop path of the literal return on its own
  chk_rwl_pop: assert property (
    (st_reg.state == RIE_EXEC && atQ4 && st_reg.op == RIE_OP_RWL)
      |=> (pcLoad && stackPop && pcNext == $past(stackTopEntry)))
    else $error("literal return did not load pc from stack top");

  // pc only moves through the stack path, never a latch
  chk_pc_held: assert property (
    !pcLoad |-> $stable(pcNext))
    else $error("pc value moved without a load");

  // s=0 and foreign words leave the data outputs alone
  chk_data_held: assert property (
    (!accumWrite && !flagsWrite && !bankWrite)
      |-> ($stable(accumData) && $stable(flagsData) && $stable(bankData)))
    else $error("data output moved without its write");

  // an idle unit only wakes on a matching word at q1
  chk_idle_stays: assert property (
    (!busy && !(instrValid && atQ1 && (isRfi || isRwl))) |=> !busy)
    else $error("unit woke without a matching word");

  // writes land three clocks after busy is first seen
  chk_load_delay: assert property (
    $rose(busy) |-> ##3 (pcLoad && busy))
    else $error("pc load not at the end of the first cycle");

  // every write strobe rides with the pc load
  chk_pulses_with_load: assert property (
    (accumWrite || flagsWrite || bankWrite || highIrqEnableSet || lowIrqEnableSet)
      |-> pcLoad)
    else $error("write strobe without pc load");

  // strobes are single clock pulses
  chk_pulse_single: assert property (
    pcLoad |=> (!pcLoad && !accumWrite && !flagsWrite && !bankWrite
                && !highIrqEnableSet && !lowIrqEnableSet))
    else $error("strobe held longer than one clock");

  // a word offered during the bubble is not taken again
  chk_busy_refuse: assert property (
    (st_reg.state == RIE_FLUSH) |=> (st_reg.state != RIE_EXEC))
    else $error("word taken while busy");

  // only the interrupt return may set an enable
  chk_enable_rfi_only: assert property (
    (highIrqEnableSet || lowIrqEnableSet) |-> (st_reg.op == RIE_OP_RFI))
    else $error("enable set by a literal return");

  // a literal return never carries the shadow selector
  chk_rwl_no_shadow: assert property (
    (busy && st_reg.op == RIE_OP_RWL) |-> !st_reg.shadowSel)
    else $error("literal return selected shadow restore");

  // covers: the three kinds of return, back to back and a refused word
  cov_rfi_shadow: cover property (pcLoad && st_reg.op == RIE_OP_RFI && st_reg.shadowSel);
  cov_busy_refused: cover property (busy && instrValid && atQ1 && (isRfi || isRwl));
  cov_rfi_plain: cover property (pcLoad && st_reg.op == RIE_OP_RFI && !st_reg.shadowSel);
  cov_rwl: cover property (pcLoad && st_reg.op == RIE_OP_RWL);
  cov_back_to_back: cover property (pcLoad ##[4:8] pcLoad);

endmodule // return_instruction_exec

// ===== verilog/rie_regs.svh
// constants for the return instruction execute unit
`ifndef RIE_REGS_SVH
`define RIE_REGS_SVH
// operand widths
`define RIE_INSTR_W 16
`define RIE_PC_W 21
`define RIE_ACC_W 8
`define RIE_FLAG_W 5
`define RIE_BANK_W 4
// return from interrupt: 0000 0000 0001 000s
`define RIE_RFI_MASK 16'hfffe
`define RIE_RFI_CODE 16'h0010
`define RIE_SHADOW_BIT 0
// return with literal: 0000 1100 kkkk kkkk
`define RIE_RWL_MASK 16'hff00
`define RIE_RWL_CODE 16'h0c00
`define RIE_LIT_HI 7
`define RIE_LIT_LO 0
// quarter-phase codes of the instruction cycle
`define RIE_Q1 2'h0
`define RIE_Q4 2'h3
// reset values
`define RIE_PC_RST 21'h000000
`define RIE_ACC_RST 8'h00
`define RIE_FLAG_RST 5'h00
`define RIE_BANK_RST 4'h0
`endif

// ===== verilog/rie_pkg.sv
// types for the return instruction execute unit
`include "rie_regs.svh"
package rie_pkg;
  // sequencer states
  typedef enum logic [1:0] {RIE_IDLE, RIE_EXEC, RIE_FLUSH} rie_state_e;
  // which return is in flight
  typedef enum logic {RIE_OP_RFI, RIE_OP_RWL} rie_op_e;
  // all state of the unit
  typedef struct packed {
    rie_state_e state;
    rie_op_e op;
    logic shadowSel;
    logic [`RIE_ACC_W-1:0] literal;
    logic [`RIE_PC_W-1:0] pcNext;
    logic [`RIE_ACC_W-1:0] accumData;
    logic [`RIE_FLAG_W-1:0] flagsData;
    logic [`RIE_BANK_W-1:0] bankData;
    logic pcLoad;
    logic accumWrite;
    logic flagsWrite;
    logic bankWrite;
    logic highSet;
    logic lowSet;
  } rie_state_s;
endpackage

// ===== bench/test_return_instruction_exec.sv
// self-checking bench for the return instruction execute unit
`timescale 1ns/1ps
`include "rie_regs.svh"
module test_return_instruction_exec
  import rie_pkg::*;
;
  // ***********************************************
  // signals and bookkeeping
  // ***********************************************
  logic clk, reset_n, instrValid, returnHighLevel; // driven inputs
  logic [1:0] qPhase = 2'h0; // quarter phase, advanced every clk
  logic [15:0] instrWord; // instruction under test
  logic [20:0] stackTopEntry; // return stack top
  logic [7:0] accumulatorShadow; // shadow copies
  logic [4:0] flagsShadow;
  logic [3:0] bankSelectShadow;
  logic busy, stackPop, pcLoad, accumWrite, flagsWrite, bankWrite; // observed
  logic highIrqEnableSet, lowIrqEnableSet;
  logic [20:0] pcNext;
  logic [7:0] accumData;
  logic [4:0] flagsData;
  logic [3:0] bankData;
  int mismatches = 0; // failed compares
  int checked = 0; // compares made
  int cycles = 0; // hang guard
  localparam int LIMIT = 2000; // about four times the planned run
  return_instruction_exec DUT (.clk(clk), .reset_n(reset_n), .qPhase(qPhase),
    .instrValid(instrValid), .instrWord(instrWord), .returnHighLevel(returnHighLevel),
    .stackTopEntry(stackTopEntry), .accumulatorShadow(accumulatorShadow),
    .flagsShadow(flagsShadow), .bankSelectShadow(bankSelectShadow), .busy(busy),
    .stackPop(stackPop), .pcLoad(pcLoad), .pcNext(pcNext), .accumWrite(accumWrite),
    .accumData(accumData), .flagsWrite(flagsWrite), .flagsData(flagsData),
    .bankWrite(bankWrite), .bankData(bankData), .highIrqEnableSet(highIrqEnableSet),
    .lowIrqEnableSet(lowIrqEnableSet));
  // ***********************************************
  // clock, phase and watchdog
  // ***********************************************
  // 200 mhz core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // phase keeps turning through reset, as the core sequencer would
  always @(negedge clk) begin
    qPhase <= qPhase + 2'h1;
  end
  // a stuck handshake must not hang the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      finish_test();
    end
  end
  // ***********************************************
  // helpers
  // ***********************************************
  // compare one value, count it, report a miss
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // 1: interrupt return, 2: literal return, 0: not ours
  function automatic logic [1:0] kind(input logic [15:0] w);
    if (w[15:1] == 15'h0008) return 2'h1;
    if (w[15:8] == 8'h0c) return 2'h2;
    return 2'h0;
  endfunction
  // verdict and end of run
  task automatic finish_test();
    if (mismatches == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // present a word at a Q1 edge and follow the eight clocks that follow;
  // the word stays offered while busy, so a second take would show up
  task automatic run(input logic [15:0] w);
    logic [1:0] k;
    logic s, hi, a, f;
    k = kind(w);
    instrValid = 1'b1;
    instrWord = w;
    {returnHighLevel, stackTopEntry, accumulatorShadow, flagsShadow, bankSelectShadow} =
      39'({$urandom, $urandom});
    s = w[0];
    hi = returnHighLevel;
    a = (k == 2'h2) || (k == 2'h1 && s);
    f = (k == 2'h1) && s;
    for (int i = 1; i < 9; i++) begin
      @(posedge clk);
      #1;
      chk("busy", busy, k != 2'h0 && i < 8);
      chk("pcLoad", pcLoad, k != 2'h0 && i == 4);
      chk("stackPop", stackPop, k != 2'h0 && i == 4);
      chk("accumWrite", accumWrite, a && i == 4);
      chk("flagsWrite", flagsWrite, f && i == 4);
      chk("bankWrite", bankWrite, f && i == 4);
      chk("highSet", highIrqEnableSet, k == 2'h1 && hi && i == 4);
      chk("lowSet", lowIrqEnableSet, k == 2'h1 && !hi && i == 4);
      if (i == 4 && k != 2'h0) chk("pcNext", pcNext, stackTopEntry);
      if (i == 4 && a) chk("accumData", accumData, s && k == 2'h1 ? accumulatorShadow
        : w[7:0]);
      if (i == 4 && f) chk("flagsData", flagsData, flagsShadow);
      if (i == 4 && f) chk("bankData", bankData, bankSelectShadow);
    end
    @(negedge clk);
  endtask
  // ***********************************************
  // main sequence
  // ***********************************************
  initial begin
    logic [15:0] corner[8];
    corner = '{16'h0010, 16'h0011, 16'h0c00, 16'h0cff, 16'h0012, 16'h0d00, 16'h8011,
      16'h1c5a};
    reset_n = 1'b0;
    instrValid = 1'b0;
    instrWord = 16'h0000;
    returnHighLevel = 1'b0;
    stackTopEntry = 21'h000000;
    accumulatorShadow = 8'h00;
    flagsShadow = 5'h00;
    bankSelectShadow = 4'h0;
    void'($urandom(32'h37e580e6));
    repeat (8) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    chk("resetPcLoad", pcLoad, 1'b0);
    // line up so the next edge samples Q1
    do @(posedge clk); while (qPhase !== 2'h3);
    @(negedge clk);
    // near misses and boundary literals, issued back to back
    foreach (corner[i]) run(corner[i]);
    // random mix weighted towards the two returns
    repeat (48) begin
      case ($urandom_range(3))
        0: run({15'h0008, 1'($urandom)});
        1: run({8'h0c, 8'($urandom)});
        default: run(16'($urandom));
      endcase
    end
    instrValid = 1'b0;
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule // test_return_instruction_exec
